// ---- design/frame_divider.sv ----
// frame divider: common slot and frame timing from the selected clock source
// assumes rc_tick and ext_tick are one-cycle enables on clk
`timescale 1ns/1ns
module frame_divider (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic rc_tick,
	input wire logic ext_tick,
	input wire logic osc_ext,
	input wire logic [2:0] frame_code,
	input wire logic duty3,
	output logic slot_tick,
	output logic frame_tick,
	output logic [1:0] com_idx,
	output logic phase
);
	logic [9:0] cnt_q;
	logic [9:0] div;
	logic [9:0] slot_last;
	logic tick;
	logic slot_end;
	logic frame_end;

	assign tick = osc_ext ? ext_tick : rc_tick;
	assign div = lcd_ctrl_pkg::frame_div(frame_code);
	// a frame spans all commons, so each slot is the divisor over the common count
	assign slot_last = (duty3 ? div / lcd_ctrl_pkg::COMMONS_3 : {2'h0, div[9:2]}) - 10'h001;
	assign slot_end = tick && (cnt_q >= slot_last);
	assign frame_end = slot_end && (com_idx == (duty3 ? 2'h2 : 2'h3));

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= 10'h000;
			com_idx <= 2'h0;
			phase <= 1'b0;
			slot_tick <= 1'b0;
			frame_tick <= 1'b0;
		end else begin
			slot_tick <= slot_end;
			frame_tick <= frame_end;
			if (slot_end) begin
				cnt_q <= 10'h000;
				com_idx <= frame_end ? 2'h0 : com_idx + 2'h1;
			end else if (tick) begin
				cnt_q <= cnt_q + 10'h001;
			end
			if (frame_end) begin
				phase <= ~phase;
			end
		end
	end
endmodule : frame_divider

// ---- design/lcd_ctrl_decode.sv ----
// lcd driver control-data decoder with ahb-lite registers, key scan and shared pins
// assumes pins are external and pass through synchronisers; one clock CLK at 50 mhz
`timescale 1ns/1ns

module lcd_ctrl_decode #(
	parameter int RC_DIV = lcd_ctrl_pkg::RC_DIV_DEFAULT,
	parameter int SCAN_SLOT = lcd_ctrl_pkg::SCAN_SLOT_DEFAULT
) (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic EXT_CLK,
	input wire logic [lcd_ctrl_pkg::KEY_RETS-1:0] KEY_RETURN,
	output logic [lcd_ctrl_pkg::KEY_LINES-1:0] KEY_SCAN_OUTPUTS,
	output logic DATA_OUT,
	output logic [lcd_ctrl_pkg::SHARED_PINS-1:0] SHARED_SEGMENT_GP_PINS,
	output logic [lcd_ctrl_pkg::SHARED_PINS-1:0] SHARED_PIN_GP_MODE,
	output logic [3:0] COM_ACTIVE,
	output logic FRAME_PHASE,
	output logic [2:0] CONTRAST_STEP,
	output logic IRQ
);
	localparam int SYNC_N = lcd_ctrl_pkg::KEY_RETS + 1;

	lcd_ctrl_pkg::ctrl_t ctrl_q;
	lcd_ctrl_pkg::stat_t stat_q;
	lcd_ctrl_pkg::stat_t stat_d;
	lcd_ctrl_pkg::stat_t mask_q;
	lcd_ctrl_pkg::key_state_t kstate_q;
	logic [lcd_ctrl_pkg::DISP_BITS-1:0] disp_q;
	logic [lcd_ctrl_pkg::KEY_BITS-1:0] key_q;
	logic key_req_q;
	logic wr_q;
	logic [7:0] waddr_q;

	// pin synchronisers: bit 0 is EXT_CLK, the rest are key returns
	logic [SYNC_N-1:0] s1_q;
	logic [SYNC_N-1:0] s2_q;
	logic [SYNC_N-1:0] s3_q;
	logic [SYNC_N-1:0] pin_lvl_q;
	wire [SYNC_N-1:0] pin_in = {KEY_RETURN, EXT_CLK};

	// address phase decode
	wire addr_ok = HSEL && HREADY && HTRANS[1];
	wire rd_req = addr_ok && !HWRITE;
	wire wr_req = addr_ok && HWRITE;
	wire [7:0] raddr = HADDR[7:0];
	wire rd_key = rd_req && (raddr == lcd_ctrl_pkg::ADDR_KEY);
	wire rd_stat = rd_req && (raddr == lcd_ctrl_pkg::ADDR_STAT);
	wire wr_ctrl = wr_q && (waddr_q == lcd_ctrl_pkg::ADDR_CTRL);
	wire wr_disp = wr_q && (waddr_q == lcd_ctrl_pkg::ADDR_DISP);
	wire wr_mask = wr_q && (waddr_q == lcd_ctrl_pkg::ADDR_MASK);
	wire [31:0] rdata =
		(raddr == lcd_ctrl_pkg::ADDR_CTRL) ? {18'h00000, ctrl_q} :
		(raddr == lcd_ctrl_pkg::ADDR_DISP) ? disp_q :
		(raddr == lcd_ctrl_pkg::ADDR_KEY) ? {key_req_q, 1'b0, key_q} :
		(raddr == lcd_ctrl_pkg::ADDR_STAT) ? {30'h00000000, stat_q} :
		(raddr == lcd_ctrl_pkg::ADDR_MASK) ? {30'h00000000, mask_q} : 32'h00000000;

	// internal rc oscillator stands in as an enable from a divider
	logic [15:0] rc_cnt_q;
	logic rc_tick_q;
	wire rc_end = (rc_cnt_q == 16'(RC_DIV - 1));

	// external clock rising edge, counted once stages two and three agree high
	wire ext_tick = s2_q[0] && s3_q[0] && !pin_lvl_q[0];

	logic slot_tick;
	logic frame_tick;
	logic [1:0] com_idx;
	logic phase;

	frame_divider u_frame (
		.clk(CLK),
		.rst_b(RST_B),
		.rc_tick(rc_tick_q),
		.ext_tick(ext_tick),
		.osc_ext(ctrl_q.oscillator_select_bit),
		.frame_code({ctrl_q.frame_divider_field[0], ctrl_q.frame_divider_field[1],
			ctrl_q.frame_divider_field[2]}),
		.duty3(ctrl_q.duty3),
		.slot_tick(slot_tick),
		.frame_tick(frame_tick),
		.com_idx(com_idx),
		.phase(phase)
	);

	// reserved counts above eight act as eight
	wire [3:0] gp_count = (ctrl_q.pin_function_count > lcd_ctrl_pkg::GP_PINS_MAX) ?
		lcd_ctrl_pkg::GP_PINS_MAX : ctrl_q.pin_function_count;
	wire blank = ctrl_q.segment_blank_bit;
	wire key_dis = ctrl_q.key_scan_disable_bit;

	logic [lcd_ctrl_pkg::SHARED_PINS-1:0] pin_d;
	logic [lcd_ctrl_pkg::SHARED_PINS-1:0] gp_sel;

	genvar g;
	generate
		for (g = 0; g < lcd_ctrl_pkg::SHARED_PINS; g++) begin : g_pin
			wire [4:0] gp_idx = ctrl_q.duty3 ? 5'(3 * g) : 5'(4 * g);
			wire [4:0] seg_idx = gp_idx + {3'h0, com_idx};
			wire seg_on = disp_q[seg_idx] && !blank;
			assign gp_sel[g] = (4'(g) < gp_count);
			// off segments follow the frame phase, so blanked pins stay ac-driven
			assign pin_d[g] = gp_sel[g] ? disp_q[gp_idx] : (phase ^ seg_on);
		end
		for (g = 0; g < SYNC_N; g++) begin : g_sync
			always_ff @(posedge CLK or negedge RST_B) begin
				if (!RST_B) begin
					s1_q[g] <= 1'b0;
					s2_q[g] <= 1'b0;
					s3_q[g] <= 1'b0;
					pin_lvl_q[g] <= 1'b0;
				end else begin
					s1_q[g] <= pin_in[g];
					s2_q[g] <= s1_q[g];
					s3_q[g] <= s2_q[g];
					if (s2_q[g] == s3_q[g]) begin
						pin_lvl_q[g] <= s3_q[g];
					end
				end
			end
		end
	endgenerate

	wire [lcd_ctrl_pkg::KEY_RETS-1:0] ret_lvl = pin_lvl_q[SYNC_N-1:1];

	// key scan: one line high per slot, returns captured at the slot end
	logic [2:0] line_q;
	logic [15:0] slot_cnt_q;
	// a slot must outlast the four-cycle return synchroniser, or returns are stale
	wire slot_done = (slot_cnt_q == 16'(SCAN_SLOT - 1));
	wire last_line = (line_q == 3'(lcd_ctrl_pkg::KEY_LINES - 1));
	wire press = |ret_lvl;
	// a pending request keeps the old data until it is read
	wire scan_start = (kstate_q == lcd_ctrl_pkg::KS_IDLE) && press && !key_dis
		&& !key_req_q;
	wire scan_end = (kstate_q == lcd_ctrl_pkg::KS_SCAN) && slot_done && last_line;
	// the last slot hands straight back to standby, never to line 0 again
	wire [2:0] next_line = scan_start ? 3'h0 : (slot_done ? line_q + 3'h1 : line_q);
	wire scan_drive = ((kstate_q == lcd_ctrl_pkg::KS_SCAN) && !scan_end) || scan_start;
	// five returns per line, line 0 in the low bits
	wire [4:0] key_base = {2'h0, line_q} * 5'h05;

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			kstate_q <= lcd_ctrl_pkg::KS_IDLE;
			line_q <= 3'h0;
			slot_cnt_q <= 16'h0000;
		end else if (key_dis) begin
			kstate_q <= lcd_ctrl_pkg::KS_IDLE;
			line_q <= 3'h0;
			slot_cnt_q <= 16'h0000;
		end else begin
			case (kstate_q)
				lcd_ctrl_pkg::KS_IDLE: begin
					if (scan_start) begin
						kstate_q <= lcd_ctrl_pkg::KS_SCAN;
					end
					line_q <= 3'h0;
					slot_cnt_q <= 16'h0000;
				end
				lcd_ctrl_pkg::KS_SCAN: begin
					slot_cnt_q <= slot_done ? 16'h0000 : slot_cnt_q + 16'h0001;
					if (slot_done) begin
						line_q <= last_line ? 3'h0 : line_q + 3'h1;
						if (last_line) begin
							kstate_q <= lcd_ctrl_pkg::KS_IDLE;
						end
					end
				end
				default: kstate_q <= lcd_ctrl_pkg::KS_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			key_q <= '0;
			key_req_q <= 1'b0;
			DATA_OUT <= 1'b1;
		end else if (key_dis) begin
			key_q <= '0;
			key_req_q <= 1'b0;
			DATA_OUT <= 1'b1;
		end else begin
			if ((kstate_q == lcd_ctrl_pkg::KS_SCAN) && slot_done) begin
				key_q[key_base +: lcd_ctrl_pkg::KEY_RETS] <= ret_lvl;
			end
			// completion wins over a read in the same cycle
			key_req_q <= scan_end || (key_req_q && !rd_key);
			DATA_OUT <= !(scan_end || (key_req_q && !rd_key));
		end
	end

	// standby drives every line high so any press is seen
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			KEY_SCAN_OUTPUTS <= '0;
		end else if (key_dis) begin
			KEY_SCAN_OUTPUTS <= '0;
		end else if (scan_drive) begin
			KEY_SCAN_OUTPUTS <= 6'h01 << next_line;
		end else begin
			KEY_SCAN_OUTPUTS <= '1;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			rc_cnt_q <= 16'h0000;
			rc_tick_q <= 1'b0;
		end else begin
			rc_cnt_q <= rc_end ? 16'h0000 : rc_cnt_q + 16'h0001;
			rc_tick_q <= rc_end;
		end
	end

	// sticky events, read clears, a new event wins over the clear
	always_comb begin
		stat_d = rd_stat ? lcd_ctrl_pkg::STAT_RESET : stat_q;
		stat_d.key_done = stat_d.key_done || scan_end;
		stat_d.frame_done = stat_d.frame_done || frame_tick;
	end

	// bus: zero wait states, write data taken in the data phase
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			wr_q <= 1'b0;
			waddr_q <= 8'h00;
			HRDATA <= 32'h00000000;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end else begin
			wr_q <= wr_req;
			waddr_q <= raddr;
			if (rd_req) begin
				HRDATA <= rdata;
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_q <= lcd_ctrl_pkg::CTRL_RESET;
			disp_q <= '0;
			mask_q <= lcd_ctrl_pkg::STAT_RESET;
			stat_q <= lcd_ctrl_pkg::STAT_RESET;
			IRQ <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= HWDATA[lcd_ctrl_pkg::CTRL_W-1:0];
			end
			if (wr_disp) begin
				disp_q <= HWDATA;
			end
			if (wr_mask) begin
				mask_q <= HWDATA[lcd_ctrl_pkg::STAT_W-1:0];
			end
			stat_q <= stat_d;
			IRQ <= |(stat_d & mask_q);
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			SHARED_SEGMENT_GP_PINS <= '0;
			SHARED_PIN_GP_MODE <= '0;
			COM_ACTIVE <= 4'h0;
			FRAME_PHASE <= 1'b0;
			CONTRAST_STEP <= 3'h0;
		end else begin
			SHARED_SEGMENT_GP_PINS <= pin_d;
			SHARED_PIN_GP_MODE <= gp_sel;
			COM_ACTIVE <= 4'h1 << com_idx;
			FRAME_PHASE <= phase;
			CONTRAST_STEP <= ctrl_q.contrast_step_field;
		end
	end
endmodule : lcd_ctrl_decode

// ---- design/lcd_ctrl_pkg.sv ----
// constants, field layout and register map of the lcd control-data decoder
// assumes one 50 mhz clock and a 32-bit ahb-lite register bus
package lcd_ctrl_pkg;

	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_DISP = 8'h04;
	localparam logic [7:0] ADDR_KEY = 8'h08;
	localparam logic [7:0] ADDR_STAT = 8'h0c;
	localparam logic [7:0] ADDR_MASK = 8'h10;

	// control word, pin_function_count in the low bits
	typedef struct packed {
		logic duty3;
		logic oscillator_select_bit;
		logic [2:0] contrast_step_field;
		logic [2:0] frame_divider_field;
		logic key_scan_disable_bit;
		logic segment_blank_bit;
		logic [3:0] pin_function_count;
	} ctrl_t;

	localparam int CTRL_W = 14;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 14'h0000;

	// sticky event bits
	typedef struct packed {
		logic frame_done;
		logic key_done;
	} stat_t;

	localparam int STAT_W = 2;
	localparam logic [STAT_W-1:0] STAT_RESET = 2'h0;

	localparam logic [3:0] GP_PINS_MAX = 4'h8;
	localparam int SHARED_PINS = 8;
	localparam int DISP_BITS = 32;
	localparam int KEY_LINES = 6;
	localparam int KEY_RETS = 5;
	localparam int KEY_BITS = 30;

	// frame divisors, keyed by {fc0, fc1, fc2}
	localparam logic [2:0] FR_CODE_768 = 3'h6;
	localparam logic [2:0] FR_CODE_576 = 3'h7;
	localparam logic [2:0] FR_CODE_384 = 3'h0;
	localparam logic [2:0] FR_CODE_288 = 3'h1;
	localparam logic [2:0] FR_CODE_192 = 3'h2;
	localparam logic [9:0] FR_DIV_768 = 10'h300;
	localparam logic [9:0] FR_DIV_576 = 10'h240;
	localparam logic [9:0] FR_DIV_384 = 10'h180;
	localparam logic [9:0] FR_DIV_288 = 10'h120;
	localparam logic [9:0] FR_DIV_192 = 10'h0c0;
	localparam logic [9:0] COMMONS_3 = 10'h003;

	// cycle counts
	localparam int RC_DIV_DEFAULT = 4;
	localparam int SCAN_SLOT_DEFAULT = 64;

	typedef enum logic [1:0] {
		KS_IDLE = 2'b01,
		KS_SCAN = 2'b10
	} key_state_t;

	function automatic logic [9:0] frame_div(input logic [2:0] code);
		case (code)
			FR_CODE_768: frame_div = FR_DIV_768;
			FR_CODE_576: frame_div = FR_DIV_576;
			FR_CODE_288: frame_div = FR_DIV_288;
			FR_CODE_192: frame_div = FR_DIV_192;
			default: frame_div = FR_DIV_384;
		endcase
	endfunction : frame_div

endpackage : lcd_ctrl_pkg

// ---- tb/key_matrix_model.sv ----
// key matrix stand-in: returns of every pressed key on a driven scan line
// assumes pressed keys are given as line*5+return, no diodes, no bounce
`timescale 1ns/1ns
module key_matrix_model (
	input wire logic [lcd_ctrl_pkg::KEY_LINES-1:0] scan,
	input wire logic [29:0] pressed,
	output logic [lcd_ctrl_pkg::KEY_RETS-1:0] ret
);
	always_comb begin
		ret = 5'h00;
		for (int l = 0; l < lcd_ctrl_pkg::KEY_LINES; l++) begin
			if (scan[l]) ret = ret | pressed[5*l +: 5];
		end
	end
endmodule : key_matrix_model

// ---- tb/lcd_ctrl_decode_monitor.sv ----
// assertions on the lcd control decoder ports
// assumes ctrl and disp are written over ahb-lite at the package offsets
`timescale 1ns/1ns
module lcd_ctrl_decode_monitor (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	input wire logic [5:0] KEY_SCAN_OUTPUTS,
	input wire logic DATA_OUT,
	input wire logic [7:0] SHARED_SEGMENT_GP_PINS,
	input wire logic [7:0] SHARED_PIN_GP_MODE,
	input wire logic [3:0] COM_ACTIVE,
	input wire logic FRAME_PHASE,
	input wire logic [2:0] CONTRAST_STEP
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);
	logic wc_q, wd_q;
	logic [31:0] ctrl_q, disp_q;
	wire take = HSEL & HREADY & HTRANS[1] & HWRITE;
	wire [3:0] gp_n = (ctrl_q[3:0] > 4'h8) ? 4'h8 : ctrl_q[3:0];
	wire [8:0] mode9 = (9'h001 << gp_n) - 9'h001;
	wire [7:0] exp_mode = mode9[7:0];
	wire [1:0] com = COM_ACTIVE[3] ? 2'h3 : COM_ACTIVE[2] ? 2'h2 : {1'b0, COM_ACTIVE[1]};
	wire [7:0] exp_gp, exp_seg;
	// shadow copies, updated on the same edge the design stores them
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			wc_q <= 1'b0;
			wd_q <= 1'b0;
			ctrl_q <= 32'h0;
			disp_q <= 32'h0;
		end else begin
			wc_q <= take && HADDR[7:0] == lcd_ctrl_pkg::ADDR_CTRL;
			wd_q <= take && HADDR[7:0] == lcd_ctrl_pkg::ADDR_DISP;
			if (wc_q) ctrl_q <= HWDATA;
			if (wd_q) disp_q <= HWDATA;
		end
	end
	for (genvar k = 0; k < 8; k++) begin : g_pin
		assign exp_gp[k] = ctrl_q[13] ? disp_q[3*k] : disp_q[4*k];
		assign exp_seg[k] = FRAME_PHASE ^ (disp_q[4*k+com] & ~ctrl_q[4]);
	end
	sequence quiet_s;
		$stable(ctrl_q) && $stable(disp_q);
	endsequence
	sequence line_s(logic [5:0] v);
		KEY_SCAN_OUTPUTS == v ##1 KEY_SCAN_OUTPUTS != v && !ctrl_q[5];
	endsequence
	gp_mode_a: assert property ($stable(ctrl_q) |-> SHARED_PIN_GP_MODE == exp_mode)
		else $error("gp mode wrong");
	gp_level_a: assert property (quiet_s |-> ((SHARED_SEGMENT_GP_PINS ^ exp_gp) & exp_mode) == 8'h00)
		else $error("gp level wrong");
	contrast_a: assert property ($stable(ctrl_q) |-> CONTRAST_STEP == ctrl_q[11:9])
		else $error("contrast wrong");
	seg_data_a: assert property (quiet_s ##0 (!ctrl_q[4] && !ctrl_q[13] &&
		$stable(FRAME_PHASE) && $stable(COM_ACTIVE)) |->
		((SHARED_SEGMENT_GP_PINS ^ exp_seg) & ~exp_mode) == 8'h00) else $error("segment wrong");
	blank_off_a: assert property ($stable(ctrl_q) && ctrl_q[4] && $stable(FRAME_PHASE) |->
		((SHARED_SEGMENT_GP_PINS ^ {8{FRAME_PHASE}}) & ~exp_mode) == 8'h00) else $error("blank wrong");
	key_off_a: assert property ($stable(ctrl_q) && ctrl_q[5] |-> KEY_SCAN_OUTPUTS == 6'h00 && DATA_OUT)
		else $error("scan not off");
	scan_step_a: assert property ($changed(KEY_SCAN_OUTPUTS) && !ctrl_q[5] &&
		$past(KEY_SCAN_OUTPUTS) inside {6'h01, 6'h02, 6'h04, 6'h08, 6'h10} |->
		KEY_SCAN_OUTPUTS == ($past(KEY_SCAN_OUTPUTS) << 1)) else $error("scan order wrong");
	scan_done_a: assert property (line_s(6'h20) |-> KEY_SCAN_OUTPUTS == 6'h3f ##[0:1] !DATA_OUT)
		else $error("scan end wrong");
	com_onehot_a: assert property ($past(RST_B) |-> $onehot(COM_ACTIVE))
		else $error("common slot not one-hot");
endmodule : lcd_ctrl_decode_monitor
bind lcd_ctrl_decode lcd_ctrl_decode_monitor monitor_u (
	.CLK(CLK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
	.HWDATA(HWDATA), .HREADY(HREADY), .KEY_SCAN_OUTPUTS(KEY_SCAN_OUTPUTS), .DATA_OUT(DATA_OUT),
	.SHARED_SEGMENT_GP_PINS(SHARED_SEGMENT_GP_PINS), .SHARED_PIN_GP_MODE(SHARED_PIN_GP_MODE),
	.COM_ACTIVE(COM_ACTIVE), .FRAME_PHASE(FRAME_PHASE), .CONTRAST_STEP(CONTRAST_STEP));

// ---- tb/lcd_ctrl_decode_tb.sv ----
// self-checking bench for the lcd control decoder
// assumes a zero-wait ahb-lite slave and the key matrix model on the scan lines
`timescale 1ns/1ns
module lcd_ctrl_decode_tb;
	localparam int RC = 2;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic ext_clk = 1'b0;
	logic [29:0] pressed = 30'h0;
	wire [31:0] hrdata;
	wire hready, hresp, data_out, phase, irq;
	wire [4:0] key_ret;
	wire [5:0] key_scan;
	wire [7:0] pins, gp_mode;
	wire [2:0] ct;
	int errors = 0;
	int comparisons = 0;
	int cyc = 0;
	int ext_n = 0;
	logic [31:0] exp_q[$], got_q[$], v;
	string name_q[$];
	event res_ev;
	lcd_ctrl_decode #(.RC_DIV(RC), .SCAN_SLOT(8)) dut_u (
		.CLK(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
		.HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
		.HRESP(hresp), .EXT_CLK(ext_clk), .KEY_RETURN(key_ret), .KEY_SCAN_OUTPUTS(key_scan),
		.DATA_OUT(data_out), .SHARED_SEGMENT_GP_PINS(pins), .SHARED_PIN_GP_MODE(gp_mode),
		.COM_ACTIVE(), .FRAME_PHASE(phase), .CONTRAST_STEP(ct), .IRQ(irq));
	key_matrix_model key_u (.scan(key_scan), .pressed(pressed), .ret(key_ret));
	always #10 clk = ~clk;
	// external clock at a sixth of the bus clock, rises counted
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc % 3 == 0) ext_clk <= ~ext_clk;
		if (cyc % 6 == 0) ext_n <= ext_n + 1;
	end
	always @(res_ev) begin
		while (got_q.size() > 0) begin
			comparisons++;
			if (got_q[0] !== exp_q[0]) begin
				errors++;
				$display("MISMATCH %s expected %h seen %h", name_q[0], exp_q[0], got_q[0]);
			end
			got_q.delete(0);
			exp_q.delete(0);
			name_q.delete(0);
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		name_q.push_back(n);
		exp_q.push_back(e);
		got_q.push_back(g);
		->res_ev;
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, v);
	endtask : wr
	function automatic logic [31:0] ctl(input logic [3:0] n, input logic bk, ks,
		input logic [2:0] fr, c3, input logic oc, d3);
		lcd_ctrl_pkg::ctrl_t c;
		c = '{d3, oc, c3, fr, ks, bk, n};
		return {18'h0, c};
	endfunction : ctl
	task automatic toggle;
		logic p;
		p = phase;
		for (int i = 0; i < 4000 && phase === p; i++) @(posedge clk);
	endtask : toggle
	task automatic press(input logic [29:0] k);
		pressed <= k;
		for (int i = 0; i < 500 && data_out !== 1'b0; i++) @(posedge clk);
		pressed <= 30'h0;
		repeat (4) @(posedge clk);
	endtask : press
	task automatic final_report;
		// let the last queued comparisons drain first
		#1;
		if (errors == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report
	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		final_report();
	end
	initial begin
		logic [31:0] d, mk;
		logic [7:0] e;
		int k, c0;
		logic [2:0] fc[5];
		int dv[5];
		fc = '{3'h3, 3'h7, 3'h0, 3'h4, 3'h2};
		dv = '{768, 576, 384, 288, 192};
		void'($urandom(32'h7ab8f095));
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		bus(1'b0, 8'h20, 32'h0, d);
		chk("unmapped", 32'h0, d);
		chk("hresp", 0, hresp);
		for (int m = 0; m < 18; m++) begin
			d = $urandom;
			mk = (32'h1 << (m % 9)) - 32'h1;
			wr(lcd_ctrl_pkg::ADDR_DISP, d);
			wr(lcd_ctrl_pkg::ADDR_CTRL, ctl(4'(m % 9), 1'b0, 1'b0, 3'h0, 3'h0, 1'b0, m > 8));
			repeat (3) @(posedge clk);
			for (int j = 0; j < 8; j++) e[j] = (m > 8) ? d[3*j] : d[4*j];
			chk("gp_mode", mk, gp_mode);
			chk("gp_pins", e & mk, pins & mk[7:0]);
		end
		for (int s = 0; s < 7; s++) begin
			wr(lcd_ctrl_pkg::ADDR_CTRL, ctl(4'h0, 1'b0, 1'b0, 3'h0, 3'(s), 1'b0, 1'b0));
			repeat (3) @(posedge clk);
			chk("contrast", s, ct);
		end
		wr(lcd_ctrl_pkg::ADDR_CTRL, ctl(4'h2, 1'b1, 1'b0, 3'h0, 3'h0, 1'b0, 1'b0));
		for (int i = 0; i < 2; i++) begin
			toggle();
			repeat (3) @(posedge clk);
			chk("blank", {8{phase}} & 8'hfc, pins & 8'hfc);
		end
		for (int i = 0; i < 5; i++) begin
			wr(lcd_ctrl_pkg::ADDR_CTRL, ctl(4'h0, 1'b0, 1'b0, fc[i], 3'h0, 1'b0, 1'b0));
			toggle();
			c0 = cyc;
			toggle();
			chk("frame_cycles", dv[i] * RC, cyc - c0);
		end
		wr(lcd_ctrl_pkg::ADDR_CTRL, ctl(4'h0, 1'b0, 1'b0, 3'h2, 3'h0, 1'b1, 1'b0));
		toggle();
		c0 = ext_n;
		toggle();
		chk("ext_frame", 192, ext_n - c0);
		wr(lcd_ctrl_pkg::ADDR_CTRL, 32'h0);
		wr(lcd_ctrl_pkg::ADDR_MASK, 32'h1);
		k = $urandom % 30;
		press(30'h1 << k);
		chk("irq_set", 1, irq);
		bus(1'b0, lcd_ctrl_pkg::ADDR_KEY, 32'h0, d);
		chk("key_data", {2'b10, 30'h1 << k}, d);
		bus(1'b0, lcd_ctrl_pkg::ADDR_STAT, 32'h0, d);
		chk("stat_key", 1, d & 32'h1);
		repeat (2) @(posedge clk);
		chk("irq_clear", 0, irq);
		wr(lcd_ctrl_pkg::ADDR_MASK, 32'h0);
		press(30'h20000000);
		chk("irq_masked", 0, irq);
		wr(lcd_ctrl_pkg::ADDR_CTRL, ctl(4'h0, 1'b0, 1'b1, 3'h0, 3'h0, 1'b0, 1'b0));
		repeat (2) @(posedge clk);
		chk("dout_disable", 1, data_out);
		bus(1'b0, lcd_ctrl_pkg::ADDR_KEY, 32'h0, d);
		chk("key_cleared", 0, d);
		pressed <= 30'($urandom);
		repeat (200) @(posedge clk);
		chk("no_scan", 1, data_out);
		chk("scan_off", 0, key_scan);
		final_report();
	end
endmodule : lcd_ctrl_decode_tb
